/* File: charger_regs_pkg.sv */
// shared constants and carrier types for the charger status register bank
package charger_regs_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] OFS_INPUT_SOURCE_STATUS = 8'h0B;
  localparam logic [7:0] OFS_FAULT_STATUS        = 8'h0C;
  localparam logic [7:0] OFS_INPUT_VOLTAGE_LIMIT = 8'h0D;
  localparam logic [7:0] OFS_THERMAL_BATTERY     = 8'h0E;

  // ***********************************************************
  // field positions and values
  // ***********************************************************
  localparam int         METHOD_BIT           = 7;
  localparam logic [6:0] LIMIT_CODE_RESET     = 7'h12;
  localparam logic [6:0] LIMIT_CODE_FLOOR     = 7'h0D;
  localparam logic [7:0] LIMIT_REG_RESET      = 8'h12;
  localparam logic [7:0] BATTERY_REG_RESET    = 8'h00;
  localparam logic [2:0] SRC_NONE             = 3'h0;
  localparam logic [2:0] SRC_USB_HOST         = 3'h1;
  localparam logic [2:0] SRC_CHARGING_PORT    = 3'h2;
  localparam logic [2:0] SRC_DEDICATED_PORT   = 3'h3;
  localparam logic [2:0] SRC_ADJUSTABLE_HV    = 3'h4;
  localparam logic [2:0] SRC_UNKNOWN          = 3'h5;
  localparam logic [2:0] SRC_NON_STANDARD     = 3'h6;
  localparam logic [2:0] SRC_OTG              = 3'h7;
  localparam logic [1:0] CHG_IDLE             = 2'h0;
  localparam logic [1:0] CHG_PRE              = 2'h1;
  localparam logic [1:0] CHG_FAST             = 2'h2;
  localparam logic [1:0] CHG_DONE             = 2'h3;
  localparam logic [1:0] ERR_NORMAL           = 2'h0;
  localparam logic [1:0] ERR_INPUT            = 2'h1;
  localparam logic [1:0] ERR_THERMAL          = 2'h2;
  localparam logic [1:0] ERR_TIMER            = 2'h3;
  localparam logic [2:0] NTC_NORMAL           = 3'h0;
  localparam logic [2:0] NTC_BUCK_COLD        = 3'h1;
  localparam logic [2:0] NTC_BUCK_HOT         = 3'h2;
  localparam logic [2:0] NTC_BOOST_COLD       = 3'h5;
  localparam logic [2:0] NTC_BOOST_HOT        = 3'h6;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic [2:0] input_source_type;
    logic [1:0] charge_state;
    logic       input_power_good;
    logic       usb_port_current_class;
    logic       min_system_regulation_flag;
  } source_status_type;

  typedef struct packed {
    logic       watchdog_fault;
    logic       boost_fault;
    logic [1:0] charge_error_code;
    logic       battery_overvoltage_flag;
    logic [2:0] thermistor_error_code;
  } fault_status_type;

  typedef struct packed {
    logic       watchdog_expired;
    logic       boost_active;
    logic       bus_overload;
    logic       bus_overvoltage;
    logic       battery_too_low;
    logic       input_fault;
    logic       thermal_shutdown;
    logic       safety_timer_expired;
    logic       battery_overvoltage;
    logic       thermistor_cold;
    logic       thermistor_hot;
  } fault_cause_type;

endpackage

/* File: charger_status_fault_regs.sv */
// status, fault, input voltage limit and battery voltage registers
`timescale 1ns/1ps
module charger_status_fault_regs (
  input  wire logic                                clk_i,
  input  wire logic                                rst_b_i,
  input  wire logic                                wr_en_i,
  input  wire logic                                rd_en_i,
  input  wire logic [7:0]                          addr_i,
  input  wire logic [7:0]                          wdata_i,
  input  wire logic [2:0]                          input_source_type_i,
  input  wire logic [1:0]                          charge_state_i,
  input  wire logic                                input_power_good_i,
  input  wire logic                                usb_high_current_i,
  input  wire logic                                min_system_regulation_i,
  input  wire charger_regs_pkg::fault_cause_type   fault_cause_i,
  input  wire logic                                relative_limit_valid_i,
  input  wire logic [6:0]                          relative_limit_code_i,
  input  wire logic                                thermal_regulation_i,
  input  wire logic                                battery_adc_valid_i,
  input  wire logic [6:0]                          battery_adc_code_i,
  output logic [7:0]                               rdata_o,
  output logic                                     rvalid_o,
  output logic                                     threshold_method_select_o,
  output logic [6:0]                               effective_limit_code_o
);

  // ***********************************************************
  // reset release
  // ***********************************************************
  logic       rst_meta_q;
  logic       rst_sync_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ***********************************************************
  // source status
  // ***********************************************************
  charger_regs_pkg::source_status_type src_q;
  charger_regs_pkg::source_status_type src_d;
  always_comb begin
    src_d.input_source_type          = input_source_type_i;
    src_d.charge_state               = charge_state_i;
    src_d.input_power_good           = input_power_good_i;
    // class forced high off usb host
    if (input_source_type_i != charger_regs_pkg::SRC_USB_HOST) begin
      src_d.usb_port_current_class = 1'b1;
    end else begin
      // 100mA reads 0, 500mA reads 1
      src_d.usb_port_current_class = usb_high_current_i;
    end
    src_d.min_system_regulation_flag = min_system_regulation_i;
  end
  // no current limit field lives here
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      src_q <= '0;
    end else begin
      src_q <= src_d;
    end
  end

  // ***********************************************************
  // fault status
  // ***********************************************************
  charger_regs_pkg::fault_status_type flt_q;
  charger_regs_pkg::fault_status_type flt_d;
  always_comb begin
    flt_d.watchdog_fault = fault_cause_i.watchdog_expired;
    // boost fault causes only count in boost
    flt_d.boost_fault = fault_cause_i.boost_active &
                        (fault_cause_i.bus_overload | fault_cause_i.bus_overvoltage |
                         fault_cause_i.battery_too_low);
    if (fault_cause_i.safety_timer_expired) begin
      flt_d.charge_error_code = charger_regs_pkg::ERR_TIMER;
    end else if (fault_cause_i.thermal_shutdown) begin
      flt_d.charge_error_code = charger_regs_pkg::ERR_THERMAL;
    end else if (fault_cause_i.input_fault) begin
      flt_d.charge_error_code = charger_regs_pkg::ERR_INPUT;
    end else begin
      flt_d.charge_error_code = charger_regs_pkg::ERR_NORMAL;
    end
    flt_d.battery_overvoltage_flag = fault_cause_i.battery_overvoltage;
    if (fault_cause_i.thermistor_cold) begin
      flt_d.thermistor_error_code = fault_cause_i.boost_active ? charger_regs_pkg::NTC_BOOST_COLD
                                                               : charger_regs_pkg::NTC_BUCK_COLD;
    end else if (fault_cause_i.thermistor_hot) begin
      flt_d.thermistor_error_code = fault_cause_i.boost_active ? charger_regs_pkg::NTC_BOOST_HOT
                                                               : charger_regs_pkg::NTC_BUCK_HOT;
    end else begin
      flt_d.thermistor_error_code = charger_regs_pkg::NTC_NORMAL;
    end
  end
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      flt_q <= '0;
    end else begin
      flt_q <= flt_d;
    end
  end

  // ***********************************************************
  // input voltage limit
  // ***********************************************************
  logic       method_q;
  logic [6:0] limit_q;
  logic       limit_wr;
  assign limit_wr = wr_en_i && (addr_i == charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT);
  // method bit written by host, resets relative
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      method_q <= charger_regs_pkg::LIMIT_REG_RESET[charger_regs_pkg::METHOD_BIT];
    end else if (limit_wr) begin
      method_q <= wdata_i[charger_regs_pkg::METHOD_BIT];
    end
  end
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      limit_q <= charger_regs_pkg::LIMIT_CODE_RESET;
    end else if (method_q && limit_wr) begin
      limit_q <= wdata_i[6:0];
    end else if (!method_q && relative_limit_valid_i) begin
      // relative mode, internal control owns it
      limit_q <= relative_limit_code_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      effective_limit_code_o <= charger_regs_pkg::LIMIT_CODE_RESET;
    end else if (limit_q < charger_regs_pkg::LIMIT_CODE_FLOOR) begin
      effective_limit_code_o <= charger_regs_pkg::LIMIT_CODE_FLOOR;
    end else begin
      effective_limit_code_o <= limit_q;
    end
  end
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      threshold_method_select_o <= 1'b0;
    end else begin
      threshold_method_select_o <= method_q;
    end
  end

  // ***********************************************************
  // thermal flag and battery voltage
  // ***********************************************************
  logic       thermal_q;
  logic [6:0] battery_q;
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      thermal_q <= charger_regs_pkg::BATTERY_REG_RESET[7];
    end else begin
      // thermal regulation flag at bit 7
      thermal_q <= thermal_regulation_i;
    end
  end
  // result held between conversions, zero at reset
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      battery_q <= charger_regs_pkg::BATTERY_REG_RESET[6:0];
    end else if (battery_adc_valid_i) begin
      battery_q <= battery_adc_code_i;
    end
  end

  // ***********************************************************
  // read port
  // ***********************************************************
  logic [7:0] rdata_d;
  // read-only words have no write path
  always_comb begin
    if (addr_i == charger_regs_pkg::OFS_INPUT_SOURCE_STATUS) begin
      rdata_d = src_q;
    end else if (addr_i == charger_regs_pkg::OFS_FAULT_STATUS) begin
      rdata_d = flt_q;
    end else if (addr_i == charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT) begin
      rdata_d = {method_q, limit_q};
    end else if (addr_i == charger_regs_pkg::OFS_THERMAL_BATTERY) begin
      rdata_d = {thermal_q, battery_q};
    end else begin
      // unmapped here: other banks answer those offsets
      rdata_d = 8'h00;
    end
  end
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= rdata_d;
      end
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_usb_class_forced;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (input_source_type_i != charger_regs_pkg::SRC_USB_HOST) |=> src_q.usb_port_current_class;
  endproperty
  a_usb_class_forced: assert property (p_usb_class_forced) else $error("usb class not forced");

  property p_usb_class_follows;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (input_source_type_i == charger_regs_pkg::SRC_USB_HOST) |=>
      (src_q.usb_port_current_class == $past(usb_high_current_i));
  endproperty
  a_usb_class_follows: assert property (p_usb_class_follows) else $error("usb class wrong");

  property p_boost_fault;
    @(posedge clk_i) disable iff (!rst_sync_q)
    !fault_cause_i.boost_active |=> !flt_q.boost_fault;
  endproperty
  a_boost_fault: assert property (p_boost_fault) else $error("boost fault outside boost");

  property p_timer_fault;
    @(posedge clk_i) disable iff (!rst_sync_q)
    fault_cause_i.safety_timer_expired |=> flt_q.charge_error_code == charger_regs_pkg::ERR_TIMER;
  endproperty
  a_timer_fault: assert property (p_timer_fault) else $error("timer fault code wrong");

  property p_ntc_boost_cold;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (fault_cause_i.boost_active && fault_cause_i.thermistor_cold) |=>
      flt_q.thermistor_error_code == charger_regs_pkg::NTC_BOOST_COLD;
  endproperty
  a_ntc_boost_cold: assert property (p_ntc_boost_cold) else $error("boost cold code wrong");

  property p_limit_readonly;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (!method_q && !relative_limit_valid_i) |=> $stable(limit_q);
  endproperty
  a_limit_readonly: assert property (p_limit_readonly) else $error("limit changed while read-only");

  property p_limit_write;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (method_q && limit_wr) |=> limit_q == $past(wdata_i[6:0]);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("absolute limit not taken");

  property p_limit_floor;
    @(posedge clk_i) disable iff (!rst_sync_q)
    ##1 (effective_limit_code_o >= charger_regs_pkg::LIMIT_CODE_FLOOR);
  endproperty
  a_limit_floor: assert property (p_limit_floor) else $error("limit below floor");

  property p_battery_hold;
    @(posedge clk_i) disable iff (!rst_sync_q)
    !battery_adc_valid_i |=> $stable(battery_q);
  endproperty
  a_battery_hold: assert property (p_battery_hold) else $error("battery result moved");

  property p_read_latency;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (rd_en_i && addr_i == charger_regs_pkg::OFS_THERMAL_BATTERY) |=>
      rvalid_o && rdata_o == {thermal_q, battery_q} || !$stable(battery_q) || !$stable(thermal_q);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("battery read wrong");

  property p_source_type;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> src_q.input_source_type == $past(input_source_type_i);
  endproperty
  a_source_type: assert property (p_source_type) else $error("source type wrong");

  property p_charge_state;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> src_q.charge_state == $past(charge_state_i);
  endproperty
  a_charge_state: assert property (p_charge_state) else $error("charge state wrong");

  property p_power_good;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> src_q.input_power_good == $past(input_power_good_i);
  endproperty
  a_power_good: assert property (p_power_good) else $error("power good flag wrong");

  property p_min_system;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> src_q.min_system_regulation_flag == $past(min_system_regulation_i);
  endproperty
  a_min_system: assert property (p_min_system) else $error("min system flag wrong");

  property p_watchdog_fault;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> flt_q.watchdog_fault == $past(fault_cause_i.watchdog_expired);
  endproperty
  a_watchdog_fault: assert property (p_watchdog_fault) else $error("watchdog fault wrong");

  property p_battery_overvoltage;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> flt_q.battery_overvoltage_flag == $past(fault_cause_i.battery_overvoltage);
  endproperty
  a_battery_overvoltage: assert property (p_battery_overvoltage) else $error("battery fault wrong");

  property p_limit_relative;
    @(posedge clk_i) disable iff (!rst_sync_q)
    (!method_q && relative_limit_valid_i) |=> limit_q == $past(relative_limit_code_i);
  endproperty
  a_limit_relative: assert property (p_limit_relative) else $error("relative limit not taken");

  property p_method_out;
    @(posedge clk_i) disable iff (!rst_sync_q)
    1'b1 |=> threshold_method_select_o == $past(method_q);
  endproperty
  a_method_out: assert property (p_method_out) else $error("method output wrong");

endmodule

/* File: host_bus_model.sv */
// host side of the register bus: single-byte reads and writes
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // ***********************************************************
  // bus tasks
  // ***********************************************************
  // host writes one byte to any register
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    addr_o  = addr;
    wdata_o = data;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    // released lines flip so a stale value is never mistaken for a live one
    addr_o  = ~addr;
    wdata_o = ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    addr_o  = addr;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    addr_o  = ~addr;
    ok      = (rvalid_i === 1'b1);
    data    = rdata_i;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the charger status register bank
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [2:0] src; logic [1:0] chg; logic pg; logic usb; logic ms;
    logic [10:0] cause; logic th; logic [6:0] bv;
    logic [7:0] e0b; logic [7:0] e0c; logic [7:0] e0e;
  } row_type;

  logic clk = 1'b0, rst_b = 1'b0, wr_en, rd_en, rvalid, rel_valid = 1'b0, adc_valid = 1'b0, method;
  logic [7:0] addr, wdata, rdata, got;
  logic [6:0] rel_code = 7'h00, eff;
  row_type cur = '0;
  logic ok;
  int mismatches = 0, checked = 0;
  row_type rows [12] = '{
    '{3'h0,2'h0,1'b0,1'b0,1'b0,11'h000,1'b0,7'h00,8'h02,8'h00,8'h00},
    '{3'h1,2'h1,1'b1,1'b0,1'b1,11'h400,1'b1,7'h7F,8'h2D,8'h80,8'hFF},
    '{3'h1,2'h2,1'b0,1'b1,1'b0,11'h300,1'b0,7'h55,8'h32,8'h40,8'h55},
    '{3'h2,2'h3,1'b1,1'b0,1'b0,11'h020,1'b1,7'h01,8'h5E,8'h10,8'h81},
    '{3'h3,2'h0,1'b0,1'b0,1'b1,11'h030,1'b0,7'h2A,8'h63,8'h20,8'h2A},
    '{3'h4,2'h1,1'b0,1'b0,1'b0,11'h02C,1'b0,7'h00,8'h8A,8'h38,8'h00},
    '{3'h5,2'h0,1'b1,1'b0,1'b0,11'h002,1'b0,7'h00,8'hA6,8'h01,8'h00},
    '{3'h6,2'h2,1'b0,1'b0,1'b0,11'h001,1'b0,7'h00,8'hD2,8'h02,8'h00},
    '{3'h7,2'h0,1'b0,1'b0,1'b0,11'h203,1'b0,7'h00,8'hE2,8'h05,8'h00},
    '{3'h7,2'h3,1'b1,1'b0,1'b0,11'h241,1'b0,7'h00,8'hFE,8'h46,8'h00},
    '{3'h7,2'h0,1'b0,1'b0,1'b1,11'h280,1'b0,7'h00,8'hE3,8'h40,8'h00},
    '{3'h1,2'h0,1'b1,1'b1,1'b0,11'h100,1'b0,7'h00,8'h26,8'h00,8'h00}
  };

  always #2.5 clk = ~clk;

  host_bus_model u_host_bus_model (
    .clk_i    (clk),
    .rdata_i  (rdata),
    .rvalid_i (rvalid),
    .wr_en_o  (wr_en),
    .rd_en_o  (rd_en),
    .addr_o   (addr),
    .wdata_o  (wdata)
  );

  charger_status_fault_regs u_charger_status_fault_regs (
    .clk_i                     (clk),
    .rst_b_i                   (rst_b),
    .wr_en_i                   (wr_en),
    .rd_en_i                   (rd_en),
    .addr_i                    (addr),
    .wdata_i                   (wdata),
    .input_source_type_i       (cur.src),
    .charge_state_i            (cur.chg),
    .input_power_good_i        (cur.pg),
    .usb_high_current_i        (cur.usb),
    .min_system_regulation_i   (cur.ms),
    .fault_cause_i             (charger_regs_pkg::fault_cause_type'(cur.cause)),
    .relative_limit_valid_i    (rel_valid),
    .relative_limit_code_i     (rel_code),
    .thermal_regulation_i      (cur.th),
    .battery_adc_valid_i       (adc_valid),
    .battery_adc_code_i        (cur.bv),
    .rdata_o                   (rdata),
    .rvalid_o                  (rvalid),
    .threshold_method_select_o (method),
    .effective_limit_code_o    (eff)
  );

  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    u_host_bus_model.read_reg(a, got, ok);
    check("read valid", 8'h01, {7'h00, ok});
    check(name, exp, got);
  endtask

  task automatic load_relative(input logic [6:0] code);
    @(negedge clk);
    rel_valid = 1'b1;
    rel_code  = code;
    @(negedge clk);
    rel_valid = 1'b0;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    results();
  end

  // ***********************************************************
  // tests
  // ***********************************************************
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    adc_valid = 1'b1;
    foreach (rows[i]) begin
      cur = rows[i];
      @(negedge clk);
      rd(charger_regs_pkg::OFS_INPUT_SOURCE_STATUS, rows[i].e0b, "source status");
      rd(charger_regs_pkg::OFS_FAULT_STATUS, rows[i].e0c, "fault status");
      rd(charger_regs_pkg::OFS_THERMAL_BATTERY, rows[i].e0e, "battery result");
      $display("row %0d done", i);
    end
    adc_valid = 1'b0;
    cur = '0;
    // relative method: host code ignored, internal control loads it
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h05);
    rd(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h12, "limit locked");
    load_relative(7'h20);
    rd(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h20, "limit relative");
    // absolute method: code taken only on the write after the method bit is set
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h85);
    rd(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'hA0, "method set");
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h85);
    rd(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h85, "limit absolute");
    check("method out", 8'h01, {7'h00, method});
    check("limit clamped", 8'h0D, {1'b0, eff});
    load_relative(7'h30);
    rd(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h85, "relative ignored");
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h9F);
    @(negedge clk);
    check("limit above floor", 8'h1F, {1'b0, eff});
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, 8'h8D);
    @(negedge clk);
    check("limit floor", 8'h0D, {1'b0, eff});
    $display("limit test done");
    // second reset in mid-run: load a fresh result first so the cleared value differs from it
    cur.bv = 7'h3C;
    adc_valid = 1'b1;
    @(negedge clk);
    adc_valid = 1'b0;
    cur = '0;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    check("method out", 8'h00, {7'h00, method});
    check("limit out", 8'h12, {1'b0, eff});
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    rd(charger_regs_pkg::OFS_INPUT_VOLTAGE_LIMIT, charger_regs_pkg::LIMIT_REG_RESET, "limit reset");
    rd(charger_regs_pkg::OFS_THERMAL_BATTERY, charger_regs_pkg::BATTERY_REG_RESET, "battery reset");
    $display("reset test done");
    // read-only registers keep their contents under writes
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_INPUT_SOURCE_STATUS, 8'hFF);
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_FAULT_STATUS, 8'hFF);
    u_host_bus_model.write_reg(charger_regs_pkg::OFS_THERMAL_BATTERY, 8'hFF);
    rd(charger_regs_pkg::OFS_INPUT_SOURCE_STATUS, 8'h02, "source after write");
    rd(charger_regs_pkg::OFS_FAULT_STATUS, 8'h00, "fault after write");
    rd(charger_regs_pkg::OFS_THERMAL_BATTERY, 8'h00, "battery after write");
    rd(8'h20, 8'h00, "unmapped read");
    $display("read-only test done");
    results();
  end
endmodule
